//--- rtl/psc_pkg.sv
package psc_pkg;

    // Shared strap pins, as bit positions of the pin vectors.
    localparam int PSC_PIN_COUNT = 9;
    localparam int PSC_IDX_EMISSION_FILTER_STRAP = 0;
    localparam int PSC_IDX_MODE_STRAP_BIT2 = 1;
    localparam int PSC_IDX_ADDR_STRAP_BIT0 = 2;
    localparam int PSC_IDX_ADDR_STRAP_BIT1 = 3;
    localparam int PSC_IDX_ADDR_STRAP_BIT2 = 4;
    localparam int PSC_IDX_NEGOTIATION_STRAP = 5;
    localparam int PSC_IDX_MODE_STRAP_BIT0 = 6;
    localparam int PSC_IDX_MODE_STRAP_BIT1 = 7;
    localparam int PSC_IDX_INTERRUPT_OUT = 8;

    // Register port.
    localparam int PSC_ADDR_W = 5;
    localparam int PSC_DATA_W = 16;
    localparam logic [PSC_ADDR_W-1:0] PSC_REG_CTRL = 5'h00;
    localparam logic [PSC_ADDR_W-1:0] PSC_REG_STRAP_STATUS = 5'h10;
    localparam logic [PSC_ADDR_W-1:0] PSC_REG_FILTER_CTRL = 5'h11;

    // Control register fields.
    localparam int PSC_CTL_SPEED = 13;
    localparam int PSC_CTL_AN_EN = 12;
    localparam int PSC_CTL_DUPLEX = 8;
    localparam logic PSC_RST_SPEED = 1'h1;
    localparam logic PSC_RST_DUPLEX = 1'h1;

    // Strap status fields.
    localparam int PSC_ST_ADDR_LSB = 0;
    localparam int PSC_ST_MODE_LSB = 5;
    localparam int PSC_ST_AN_STRAP = 8;
    localparam int PSC_ST_NAND_STRAP = 9;
    localparam int PSC_ST_FILT_STRAP = 10;

    // Filter control field.
    localparam int PSC_FC_FILT_EN = 0;

    // Management address.
    localparam int PSC_PHY_ADDR_W = 5;
    localparam logic [1:0] PSC_ADDR_HIGH_DEFAULT = 2'h0;

    // Mode strap codes.
    localparam logic [2:0] PSC_CODE_NORMAL_NOX = 3'h1;
    localparam logic [2:0] PSC_CODE_B2B_X = 3'h5;
    localparam logic [2:0] PSC_CODE_NORMAL_X = 3'h7;

    typedef enum logic [1:0] {
        PSC_MODE_RESERVED,
        PSC_MODE_NORMAL,
        PSC_MODE_BACK_TO_BACK
    } psc_mode_t;

endpackage

//--- rtl/psc_pin_sync.sv
`timescale 1ns/100ps
module psc_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock.
    input  wire logic             clk,
    // Asynchronous pin levels and their filtered copy.
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_filt
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] filt;
    } psc_sync_t;

    psc_sync_t st;
    psc_sync_t next_st;

    // The chain runs through reset so that straps settle before release.
    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.filt = (st.s2 & st.s3) | (st.filt & (st.s2 ^ st.s3));
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign pin_filt = st.filt;
endmodule

//--- rtl/phy_strap_config_latch.sv
`timescale 1ns/100ps
// Contract
// - Sample all strap pins at reset release and keep them as settings.
// - Management address low three bits from straps, upper two bits zero.
// - Negotiation strap loads control bit 12; high disables negotiation.
// - Test strap low at release enters NAND-tree test mode.
// - Filter strap low at release enables emission filter, high disables.
// - Receive data valid whenever receive data-valid is driven to the MAC.
// - Strap pins stay released in reset and drive outputs after it, the interrupt pin only while IRQ is high.
module phy_strap_config_latch
    import psc_pkg::*;
(
    // Clock and reset.
    input  wire logic                               SYS_CLK,
    input  wire logic                               RST_N,
    // Shared strap pins.
    input  wire logic [psc_pkg::PSC_PIN_COUNT-1:0]  STRAP_PIN_IN,
    output logic      [psc_pkg::PSC_PIN_COUNT-1:0]  STRAP_PIN_OUT,
    output logic      [psc_pkg::PSC_PIN_COUNT-1:0]  STRAP_PIN_OE,
    // MAC transmit pins.
    input  wire logic                               TXEN,
    input  wire logic [1:0]                         TXD,
    // Transceiver side.
    input  wire logic [1:0]                         RX_DATA,
    input  wire logic                               RX_VALID,
    input  wire logic                               RX_ERR,
    input  wire logic                               REF_CLK_DRIVE,
    input  wire logic                               IRQ,
    output logic [1:0]                              TX_DATA,
    output logic                                    TX_VALID,
    // Register port.
    input  wire logic [psc_pkg::PSC_ADDR_W-1:0]     ADDR,
    input  wire logic [psc_pkg::PSC_DATA_W-1:0]     WDATA,
    input  wire logic                               WR,
    input  wire logic                               RD,
    output logic      [psc_pkg::PSC_DATA_W-1:0]     RDATA,
    // Configuration.
    output logic                                    STRAP_VALID,
    output logic [psc_pkg::PSC_PHY_ADDR_W-1:0]      PHY_ADDR,
    output psc_pkg::psc_mode_t                      MODE,
    output logic                                    XOVER_EN,
    output logic                                    AN_ENABLE,
    output logic                                    SPEED_100,
    output logic                                    FULL_DUPLEX,
    output logic                                    NAND_TREE_EN,
    output logic                                    EMI_FILTER_EN
);
    import psc_pkg::*;

    typedef struct packed {
        logic                  loaded;
        logic [2:0]            addr_low;
        logic [2:0]            mode;
        logic                  an_strap;
        logic                  nand_strap;
        logic                  filt_strap;
        logic                  speed;
        logic                  an_en;
        logic                  duplex;
        logic                  filt_en;
        logic [PSC_DATA_W-1:0] rdata;
        logic [1:0]            rxd;
        logic                  rx_dv;
        logic                  rx_err;
        logic                  ref_out;
        logic                  irq;
        logic [1:0]            txd;
        logic                  tx_en;
    } psc_state_t;

    localparam psc_state_t PSC_STATE_RESET = '{
        speed:   PSC_RST_SPEED,
        duplex:  PSC_RST_DUPLEX,
        default: '0
    };

    psc_state_t                 st;
    psc_state_t                 next_st;
    logic [PSC_PIN_COUNT-1:0]   strap;
    logic [PSC_DATA_W-1:0]      ctrl_word;
    logic [PSC_DATA_W-1:0]      status_word;
    logic [PSC_DATA_W-1:0]      filter_word;

    psc_pin_sync #(
        .WIDTH (PSC_PIN_COUNT)
    ) u_sync (
        .clk      (SYS_CLK),
        .pin_in   (STRAP_PIN_IN),
        .pin_filt (strap)
    );

    always_comb begin
        ctrl_word = '0;
        ctrl_word[PSC_CTL_SPEED] = st.speed;
        ctrl_word[PSC_CTL_AN_EN] = st.an_en;
        ctrl_word[PSC_CTL_DUPLEX] = st.duplex;
        status_word = '0;
        status_word[PSC_ST_ADDR_LSB +: 3] = st.addr_low;
        status_word[PSC_ST_MODE_LSB +: 3] = st.mode;
        status_word[PSC_ST_AN_STRAP] = st.an_strap;
        status_word[PSC_ST_NAND_STRAP] = st.nand_strap;
        status_word[PSC_ST_FILT_STRAP] = st.filt_strap;
        filter_word = '0;
        filter_word[PSC_FC_FILT_EN] = st.filt_en;
    end

    always_comb begin
        next_st = st;
        // Datapath pins are retimed once; valid and data move together.
        next_st.rxd = RX_DATA;
        next_st.rx_dv = RX_VALID;
        next_st.rx_err = RX_ERR;
        next_st.ref_out = REF_CLK_DRIVE;
        next_st.irq = IRQ;
        // Transmit data is taken as valid only beside transmit enable.
        next_st.tx_en = TXEN;
        next_st.txd = TXD;
        next_st.rdata = '0;
        if (!st.loaded) begin
            // First edge after release: take every strap once.
            next_st.loaded = 1'h1;
            next_st.addr_low = {strap[PSC_IDX_ADDR_STRAP_BIT2],
                                strap[PSC_IDX_ADDR_STRAP_BIT1],
                                strap[PSC_IDX_ADDR_STRAP_BIT0]};
            next_st.mode = {strap[PSC_IDX_MODE_STRAP_BIT2],
                            strap[PSC_IDX_MODE_STRAP_BIT1],
                            strap[PSC_IDX_MODE_STRAP_BIT0]};
            next_st.an_strap = strap[PSC_IDX_NEGOTIATION_STRAP];
            next_st.an_en = ~strap[PSC_IDX_NEGOTIATION_STRAP];
            next_st.nand_strap = strap[PSC_IDX_INTERRUPT_OUT];
            next_st.filt_strap = strap[PSC_IDX_EMISSION_FILTER_STRAP];
            next_st.filt_en = ~strap[PSC_IDX_EMISSION_FILTER_STRAP];
        end else if (WR) begin
            // Only software writes alter loaded settings afterwards.
            case (ADDR)
                PSC_REG_CTRL: begin
                    next_st.speed = WDATA[PSC_CTL_SPEED];
                    next_st.an_en = WDATA[PSC_CTL_AN_EN];
                    next_st.duplex = WDATA[PSC_CTL_DUPLEX];
                end
                PSC_REG_FILTER_CTRL: begin
                    next_st.filt_en = WDATA[PSC_FC_FILT_EN];
                end
                default: begin
                    next_st.filt_en = st.filt_en;
                end
            endcase
        end
        if (RD) begin
            case (ADDR)
                PSC_REG_CTRL:         next_st.rdata = ctrl_word;
                PSC_REG_STRAP_STATUS: next_st.rdata = status_word;
                PSC_REG_FILTER_CTRL:  next_st.rdata = filter_word;
                default:              next_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            st <= PSC_STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        case (st.mode)
            PSC_CODE_NORMAL_NOX: MODE = PSC_MODE_NORMAL;
            PSC_CODE_B2B_X:      MODE = PSC_MODE_BACK_TO_BACK;
            PSC_CODE_NORMAL_X:   MODE = PSC_MODE_NORMAL;
            default:             MODE = PSC_MODE_RESERVED;
        endcase
        XOVER_EN = st.loaded && (st.mode == PSC_CODE_B2B_X ||
                                 st.mode == PSC_CODE_NORMAL_X);
    end

    // Pins stay released until the straps are taken.
    always_comb begin
        STRAP_PIN_OE = {PSC_PIN_COUNT{st.loaded}};
        STRAP_PIN_OE[PSC_IDX_INTERRUPT_OUT] = st.loaded & st.irq;
        STRAP_PIN_OUT = '0;
        STRAP_PIN_OUT[PSC_IDX_EMISSION_FILTER_STRAP] = st.rx_err;
        STRAP_PIN_OUT[PSC_IDX_MODE_STRAP_BIT2] = st.rx_dv;
        STRAP_PIN_OUT[PSC_IDX_ADDR_STRAP_BIT2] = st.rxd[1];
        STRAP_PIN_OUT[PSC_IDX_NEGOTIATION_STRAP] = st.rxd[0];
        STRAP_PIN_OUT[PSC_IDX_MODE_STRAP_BIT0] = st.ref_out;
    end

    assign RDATA = st.rdata;
    assign STRAP_VALID = st.loaded;
    assign PHY_ADDR = {PSC_ADDR_HIGH_DEFAULT, st.addr_low};
    assign AN_ENABLE = st.an_en;
    assign SPEED_100 = st.speed;
    assign FULL_DUPLEX = st.duplex;
    assign NAND_TREE_EN = st.loaded & ~st.nand_strap;
    assign EMI_FILTER_EN = st.filt_en;
    assign TX_DATA = st.txd;
    assign TX_VALID = st.tx_en;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    chk_pins_released: assert property (
        disable iff (1'h0) !RST_N |=> STRAP_PIN_OE == '0)
        else $error("strap pins driven during reset");
    chk_pins_driven: assert property (
        $rose(st.loaded) |-> ##1
        STRAP_PIN_OE[PSC_IDX_ADDR_STRAP_BIT1] [*3])
        else $error("strap pins not driven after reset");
    chk_addr_capture: assert property (
        $rose(st.loaded) |-> PHY_ADDR == {2'h0,
        $past(strap[PSC_IDX_ADDR_STRAP_BIT2]),
        $past(strap[PSC_IDX_ADDR_STRAP_BIT1]),
        $past(strap[PSC_IDX_ADDR_STRAP_BIT0])})
        else $error("address not taken from straps");
    chk_strap_hold: assert property (
        st.loaded && $past(st.loaded) |->
        $stable(PHY_ADDR) && $stable(st.mode) && $stable(NAND_TREE_EN))
        else $error("captured strap changed");
    chk_mode_decode: assert property (
        st.loaded && st.mode == PSC_CODE_NORMAL_NOX |->
        !XOVER_EN && MODE == PSC_MODE_NORMAL)
        else $error("mode 001 decoded wrongly");
    chk_an_capture: assert property (
        $rose(st.loaded) |->
        AN_ENABLE == !$past(strap[PSC_IDX_NEGOTIATION_STRAP]))
        else $error("negotiation strap not loaded");
    chk_nand_capture: assert property (
        $rose(st.loaded) |->
        NAND_TREE_EN == !$past(strap[PSC_IDX_INTERRUPT_OUT]))
        else $error("test strap not loaded");
    chk_filter_capture: assert property (
        $rose(st.loaded) |->
        EMI_FILTER_EN == !$past(strap[PSC_IDX_EMISSION_FILTER_STRAP]))
        else $error("filter strap not loaded");
    chk_rx_pair: assert property (
        $past(st.loaded) && st.loaded && $past(RX_VALID) |->
        STRAP_PIN_OUT[PSC_IDX_MODE_STRAP_BIT2] &&
        STRAP_PIN_OUT[PSC_IDX_ADDR_STRAP_BIT2] == $past(RX_DATA[1]) &&
        STRAP_PIN_OUT[PSC_IDX_NEGOTIATION_STRAP] == $past(RX_DATA[0]))
        else $error("receive data not beside data valid");
    chk_read_slot: assert property (
        RD && ADDR == PSC_REG_CTRL && !WR |=>
        RDATA[PSC_CTL_AN_EN] == $past(st.an_en))
        else $error("control read wrong");

    cov_capture: cover property ($rose(st.loaded));
    cov_ctrl_write: cover property (st.loaded && WR &&
        ADDR == PSC_REG_CTRL ##2 RD && ADDR == PSC_REG_CTRL);
    cov_rx_frame: cover property (st.loaded && RX_VALID [*4]);
    cov_b2b: cover property (MODE == PSC_MODE_BACK_TO_BACK);
endmodule

//--- verification/psc_board_model.sv
`timescale 1ns/100ps
module psc_board_model
    import psc_pkg::*;
(
    // Strap resistor levels fitted on the board.
    input  wire logic [psc_pkg::PSC_PIN_COUNT-1:0] strap_level,
    // Device side of the shared pins.
    input  wire logic [psc_pkg::PSC_PIN_COUNT-1:0] pin_out,
    input  wire logic [psc_pkg::PSC_PIN_COUNT-1:0] pin_oe,
    output logic      [psc_pkg::PSC_PIN_COUNT-1:0] pin_level
);
    // A released pin settles to its resistor, never to a stale drive.
    always_comb begin
        for (int i = 0; i < PSC_PIN_COUNT; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : strap_level[i];
        end
    end
endmodule

//--- verification/phy_strap_config_latch_tb.sv
`timescale 1ns/100ps
module phy_strap_config_latch_tb;
    import psc_pkg::*;
    logic                      sys_clk, rst_n, txen, rx_valid, rx_err;
    logic                      ref_drive, irq, wr, rd, tx_valid, valid;
    logic                      xover, an_en, spd, fdx, nand_en, emi_en;
    logic [1:0]                txd, rx_data, tx_data;
    logic [PSC_PIN_COUNT-1:0]  straps, pin_in, pin_out, pin_oe, cap, e;
    logic [PSC_ADDR_W-1:0]     addr;
    logic [PSC_DATA_W-1:0]     wdata, rdata;
    logic [PSC_PHY_ADDR_W-1:0] phy_addr;
    logic [31:0]               r;
    logic [2:0]                c;
    psc_mode_t                 mode;
    int                        miscompares = 0;
    int                        cmp_count = 0;
    int                        an_m, filt_m, sd_m;

    phy_strap_config_latch dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .STRAP_PIN_IN(pin_in), .STRAP_PIN_OUT(pin_out),
        .STRAP_PIN_OE(pin_oe), .TXEN(txen), .TXD(txd), .RX_DATA(rx_data),
        .RX_VALID(rx_valid), .RX_ERR(rx_err), .REF_CLK_DRIVE(ref_drive),
        .IRQ(irq), .TX_DATA(tx_data), .TX_VALID(tx_valid), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .STRAP_VALID(valid), .PHY_ADDR(phy_addr), .MODE(mode),
        .XOVER_EN(xover), .AN_ENABLE(an_en), .SPEED_100(spd),
        .FULL_DUPLEX(fdx), .NAND_TREE_EN(nand_en), .EMI_FILTER_EN(emi_en));
    psc_board_model board (.strap_level(straps), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_level(pin_in));

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: port got %h want %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk);
        wr <= 1'h0;
    endtask

    // Register read compare: data stands only in the cycle after the strobe.
    task automatic reg_read(input logic [4:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        rd <= 1'h1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'h0;
        #1;
        cmp_count++;
        if (rdata !== exp) begin
            miscompares++;
            $display("Error at %0t: read %h got %h want %h", $time, a, rdata,
                     exp);
        end
    endtask

    function automatic psc_mode_t exp_mode(input logic [2:0] code);
        case (code)
            PSC_CODE_NORMAL_NOX, PSC_CODE_NORMAL_X: return PSC_MODE_NORMAL;
            PSC_CODE_B2B_X: return PSC_MODE_BACK_TO_BACK;
            default: return PSC_MODE_RESERVED;
        endcase
    endfunction

    // Expected control word from the model's speed, duplex and enable.
    function automatic logic [15:0] ctrl_exp();
        logic [15:0] v;
        v = '0;
        v[PSC_CTL_SPEED] = sd_m[1];
        v[PSC_CTL_AN_EN] = an_m[0];
        v[PSC_CTL_DUPLEX] = sd_m[0];
        return v;
    endfunction

    task automatic check_cfg();
        c = {cap[PSC_IDX_MODE_STRAP_BIT2], cap[PSC_IDX_MODE_STRAP_BIT1],
             cap[PSC_IDX_MODE_STRAP_BIT0]};
        chk(16'(valid), 16'h1);
        chk(16'(phy_addr), {11'h0, PSC_ADDR_HIGH_DEFAULT,
            cap[PSC_IDX_ADDR_STRAP_BIT2], cap[PSC_IDX_ADDR_STRAP_BIT1],
            cap[PSC_IDX_ADDR_STRAP_BIT0]});
        chk(16'(mode), 16'(exp_mode(c)));
        chk(16'(xover), 16'(c == 3'h5 || c == 3'h7));
        chk(16'(an_en), 16'(an_m));
        chk(16'(nand_en), 16'(!cap[PSC_IDX_INTERRUPT_OUT]));
        chk(16'(emi_en), 16'(filt_m));
        chk({14'h0, spd, fdx}, 16'(sd_m));
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #2 sys_clk = ~sys_clk;
    end

    initial begin
        #80000;
        miscompares++;
        $display("Error at %0t: run timed out", $time);
        tally_and_finish();
    end

    initial begin
        {rst_n, txen, rx_valid, rx_err, ref_drive, irq, wr, rd} = '0;
        {txd, rx_data, addr, wdata, straps} = '0;
        void'($urandom(32'hDC0D));
        for (int code = 0; code < 8; code++) begin
            r = $urandom;
            @(posedge sys_clk);
            rst_n <= 1'h0;
            {irq, wr, rd} <= 3'h0;
            straps <= {r[8], code[1], code[0], r[5:2], code[2], r[0]};
            repeat (16) @(posedge sys_clk);
            #1;
            chk({7'h0, pin_oe}, 16'h0);
            chk(16'(valid), 16'h0);
            cap = straps;
            an_m = !cap[PSC_IDX_NEGOTIATION_STRAP];
            filt_m = !cap[PSC_IDX_EMISSION_FILTER_STRAP];
            sd_m = {PSC_RST_SPEED, PSC_RST_DUPLEX};
            @(posedge sys_clk);
            rst_n <= 1'h1;
            @(posedge sys_clk);
            #1;
            check_cfg();
            repeat (6) begin
                r = $urandom;
                @(posedge sys_clk);
                txen <= r[0];
                txd <= r[2:1];
                {rx_err, rx_valid, rx_data, irq, ref_drive} <= r[8:3];
                @(posedge sys_clk);
                #1;
                e = '0;
                e[PSC_IDX_EMISSION_FILTER_STRAP] = r[8];
                e[PSC_IDX_MODE_STRAP_BIT2] = r[7];
                e[PSC_IDX_ADDR_STRAP_BIT2] = r[6];
                e[PSC_IDX_NEGOTIATION_STRAP] = r[5];
                e[PSC_IDX_MODE_STRAP_BIT0] = r[3];
                chk({7'h0, pin_out}, {7'h0, e});
                chk({7'h0, pin_oe}, {7'h0, r[4], 8'hFF});
                chk({13'h0, tx_valid, tx_data},
                    {13'h0, r[0], r[2:1]});
            end
            reg_read(PSC_REG_STRAP_STATUS, {5'h0, cap[0], cap[8],
                cap[5], c, 2'h0, cap[4], cap[3], cap[2]});
            reg_read(PSC_REG_CTRL, ctrl_exp());
            an_m = !an_m;
            filt_m = !filt_m;
            sd_m = r[10:9];
            reg_write(PSC_REG_CTRL, ctrl_exp());
            reg_read(PSC_REG_CTRL, ctrl_exp());
            reg_write(PSC_REG_FILTER_CTRL, 16'(filt_m));
            reg_write(PSC_REG_STRAP_STATUS, 16'hFFFF);
            reg_write(5'h1F, 16'hFFFF);
            reg_read(5'h1F, 16'h0000);
            reg_read(PSC_REG_FILTER_CTRL, 16'(filt_m));
            straps <= ~cap;
            repeat (8) @(posedge sys_clk);
            #1;
            check_cfg();
        end
        tally_and_finish();
    end
endmodule
